// ===== src/dwl_pkg.sv
// Functional notes
// [RULE_01] power-up presets both wipers to midscale
// [RULE_02] midscale preset value is 0x80
// [RULE_03] link is data, chip select, clock only
// [RULE_04] host sends nine bits, msb first
// [RULE_05] shift data on rising clock while selected
// [RULE_06] host drives clean glitch-free serial clock
// [RULE_07] chip select rising copies word to wiper
// [RULE_08] extra bits: keep only last nine
// [RULE_09] bit 8 channel, bits 7..0 data
// [RULE_10] channel bit 0 first wiper, 1 second
// [RULE_11] each wiper holds unsigned 8-bit code
package dwl_pkg;
  localparam int WORD_BITS      = 9;
  localparam int CODE_BITS      = 8;
  localparam int CHAN_BIT_POS   = 8;
  localparam int CHANNELS       = 2;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam int MCLK_HZ        = 50000000;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS * (MCLK_HZ / 1000000)) / 2000;
  localparam logic [3:0] HALF_CNT_MAX = 4'(SCLK_HALF_CYC - 1);
  localparam logic [3:0] BIT_CNT_INIT = 4'(WORD_BITS - 1);
  typedef enum logic [1:0] {
    DWL_IDLE = 2'h0,
    DWL_LOW  = 2'h1,
    DWL_HIGH = 2'h3,
    DWL_DONE = 2'h2
  } dwl_state_t;
endpackage

// ===== src/dwl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dwl_if;
  logic serial_data_in;
  logic cs_n;
  logic sclk;
  modport host (output serial_data_in, output cs_n, output sclk);
  modport dev  (input serial_data_in, input cs_n, input sclk);
endinterface
`default_nettype wire

// ===== src/dwl_host.sv
`timescale 1ns/100ps
`default_nettype none
module dwl_host (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 req,
  input  wire logic                 req_chan,
  input  wire logic [7:0]           req_code,
  output logic                      busy,
  dwl_if.host                       link
);
  import dwl_pkg::*;
  dwl_state_t state_reg;
  logic [3:0] half_reg;
  logic [3:0] bit_reg;
  logic [8:0] word_reg;
  logic       sclk_reg;
  logic       cs_n_reg;
  logic       sdo_reg;
  logic       busy_reg;
  wire        half_done = (half_reg == 4'h0);
  wire        last_bit  = (bit_reg == 4'h0);
  assign link.sclk           = sclk_reg; // RULE_06
  assign link.cs_n           = cs_n_reg;
  assign link.serial_data_in = sdo_reg; // RULE_03
  assign busy                = busy_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= DWL_IDLE;
      half_reg  <= 4'h0;
      bit_reg   <= 4'h0;
      word_reg  <= 9'h000;
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      sdo_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      half_reg <= half_done ? HALF_CNT_MAX : half_reg - 4'h1;
      case (state_reg)
        DWL_IDLE: begin
          sclk_reg <= 1'b0;
          if (req) begin
            word_reg  <= {req_chan, req_code}; // RULE_09
            sdo_reg   <= req_chan; // RULE_04
            cs_n_reg  <= 1'b0;
            busy_reg  <= 1'b1;
            bit_reg   <= BIT_CNT_INIT;
            half_reg  <= HALF_CNT_MAX;
            state_reg <= DWL_LOW;
          end
        end
        DWL_LOW: begin
          if (half_done) begin
            sclk_reg  <= 1'b1;
            state_reg <= DWL_HIGH;
          end
        end
        DWL_HIGH: begin
          if (half_done) begin
            sclk_reg <= 1'b0;
            if (last_bit) begin
              state_reg <= DWL_DONE;
            end else begin
              word_reg  <= {word_reg[7:0], 1'b0}; // RULE_04
              sdo_reg   <= word_reg[7];
              bit_reg   <= bit_reg - 4'h1;
              state_reg <= DWL_LOW;
            end
          end
        end
        DWL_DONE: begin
          if (half_done) begin
            cs_n_reg  <= 1'b1;
            busy_reg  <= 1'b0;
            state_reg <= DWL_IDLE;
          end
        end
        default: state_reg <= DWL_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== src/dwl_dev.sv
`timescale 1ns/100ps
`default_nettype none
module dwl_dev (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  dwl_if.dev                        link,
  output logic [7:0]                wiper_code_a,
  output logic [7:0]                wiper_code_b,
  output logic                      load_pulse
);
  import dwl_pkg::*;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  logic [8:0] shift_reg;
  logic [7:0] wiper_code_register [CHANNELS];
  logic       load_reg;
  wire        sclk_s = sync2_reg[0];
  wire        cs_n_s = sync2_reg[1];
  wire        sdi_s  = sync2_reg[2];
  wire        sclk_rise = sclk_s & ~prev_reg[0];
  wire        cs_rise   = cs_n_s & ~prev_reg[1];
  wire        channel_select_bit = shift_reg[CHAN_BIT_POS]; // RULE_09
  wire [7:0]  wiper_data_bits    = shift_reg[CODE_BITS-1:0];
  assign wiper_code_a = wiper_code_register[0]; // RULE_11
  assign wiper_code_b = wiper_code_register[1];
  assign load_pulse   = load_reg;
  // two-flop sync on all pins; the slow link clock makes the added latency harmless
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // idle pin levels: deselected, clock low, so no false edge follows reset
      sync1_reg <= 3'h2;
      sync2_reg <= 3'h2;
      prev_reg  <= 3'h2;
    end else begin
      sync1_reg <= {link.serial_data_in, link.cs_n, link.sclk};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= 9'h000;
    end else if (sclk_rise && !cs_n_s) begin
      shift_reg <= {shift_reg[7:0], sdi_s}; // RULE_05 RULE_08
    end
  end
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          wiper_code_register[ch] <= WIPER_RESET; // RULE_01 RULE_02
        end else if (cs_rise && (channel_select_bit == ch[0])) begin
          wiper_code_register[ch] <= wiper_data_bits; // RULE_07 RULE_10
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= cs_rise;
    end
  end
endmodule
`default_nettype wire

// ===== verification/dwl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dwl_asserts (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic serial_data_in,
  input wire logic cs_n,
  input wire logic sclk
);
  logic [3:0] rises_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // cleared while deselected so no edge carries into the next word
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) rises_reg <= 4'h0;
    else if (cs_n) rises_reg <= 4'h0;
    else if ($rose(sclk)) rises_reg <= rises_reg + 4'h1;
  AST_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("clock moved while deselected");
  AST_HIGH_HALF: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk)
    else $error("bad high half");
  AST_LOW_HALF: assert property ($fell(sclk) |=> !sclk [*3] ##1 (sclk || cs_n))
    else $error("bad low half");
  AST_DATA_HELD: assert property (sclk |-> $stable(serial_data_in))
    else $error("data moved while clock high");
  AST_FIRST_RISE: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
    else $error("first rise late");
  AST_NINE_BITS: assert property ($rose(cs_n) |-> rises_reg == 4'h9)
    else $error("word not nine bits");
  AST_DATA_MOVES: assert property ($changed(serial_data_in) |-> $fell(sclk) || $fell(cs_n) || cs_n)
    else $error("data moved off a falling edge");
  AST_CS_GAP: assert property ($rose(cs_n) |-> !$past(sclk, 4) && $past(sclk, 5))
    else $error("select rose off the frame end");
  cover property ($rose(cs_n));
  cover property ($rose(cs_n) ##1 $fell(cs_n));
  cover property ($fell(sclk) ##4 $rose(cs_n));
endmodule
`default_nettype wire

// ===== verification/tb_dual_wiper_serial_loader.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dual_wiper_serial_loader;
  logic        mclk, reset_n, req, req_chan, busy, load_pulse;
  logic [7:0]  req_code, wiper_code_a, wiper_code_b, ma = 8'h80, mb = 8'h80;
  logic [15:0] q[$], e;
  logic [31:0] s = 32'h0000CC6F, r;
  int          miscompares = 0, n_checks = 0;
  dwl_if link_if();
  dwl_host u_dwl_host(.mclk(mclk), .reset_n(reset_n), .req(req), .req_chan(req_chan),
    .req_code(req_code), .busy(busy), .link(link_if));
  dwl_dev u_dwl_dev(.mclk(mclk), .reset_n(reset_n), .link(link_if),
    .wiper_code_a(wiper_code_a), .wiper_code_b(wiper_code_b), .load_pulse(load_pulse));
  dwl_asserts u_dwl_asserts(.mclk(mclk), .reset_n(reset_n), .cs_n(link_if.cs_n),
    .serial_data_in(link_if.serial_data_in), .sclk(link_if.sclk));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // next word may start as soon as busy drops, so words run back to back
  task automatic send(input logic c, input logic [7:0] d);
    do begin
      @(posedge mclk);
      #1;
    end while (busy !== 1'b0);
    req = 1'b1;
    req_chan = c;
    req_code = d;
    if (c) mb = d;
    else ma = d;
    q.push_back({ma, mb});
    @(posedge mclk);
    #1 req = 1'b0;
  endtask
  // a pulse with nothing queued pops a default and so shows as a mismatch
  always @(posedge mclk) begin
    #2;
    if (load_pulse === 1'b1) begin
      e = q.pop_front();
      chk(wiper_code_a, e[15:8]);
      chk(wiper_code_b, e[7:0]);
    end
  end
  initial begin
    reset_n = 1'b0;
    req = 1'b0;
    req_chan = 1'b0;
    req_code = 8'h00;
    repeat (20) @(posedge mclk);
    #1 reset_n = 1'b1;
    chk(wiper_code_a, ma);
    chk(wiper_code_b, mb);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      send(r[8], i == 0 ? 8'h00 : i == 1 ? 8'hFF : r[7:0]);
    end
    repeat (80) @(posedge mclk);
    chk(8'(q.size()), 8'h00);
    give_verdict();
  end
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
